// File: design/safety_interlock_logic.sv
// safety interlock top: sensor decode, sequencing, outputs, apb slave
//
// Implementation choices: register access over APB and the register addresses.
`timescale 1ns/100ps
`include "safety_interlock_defs.svh"

module safety_interlock_logic #(
   parameter int DISC_CYCLES = 16  // discrepancy tolerance per pair
) (
   // clock and reset
   input  wire logic        mclk,
   input  wire logic        reset_n,
   // safe input unit channels
   input  wire logic [7:0]  safeIn,
   // safe output unit channels
   output logic      [3:0]  safeOut,
   // safe power unit channels
   output logic      [2:0]  powerOut,
   // standard outputs behind the power unit
   output logic      [3:0]  standardOut,
   // axis monitoring selection
   output logic      [1:0]  axisMode,
   output logic             stopTypeC,
   output logic             stopTypeD,
   // interrupt
   output logic             irq,
   // apb slave
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [7:0]  paddr,
   input  wire logic [31:0] pwdata,
   output logic      [31:0] prdata,
   output logic             pready,
   output logic             pslverr
);

   // reset synchroniser
   logic rstMeta_q;   // first stage, read only by second
   logic rstN;        // released reset used by the design

   always_ff @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
         rstMeta_q <= 1'b0;
         rstN      <= 1'b0;
      end else begin
         rstMeta_q <= 1'b1;
         rstN      <= rstMeta_q;
      end
   end

   // decoded sensor states
   logic       estopOk;      // emergency stop released
   logic       doorClosed;   // protective door closed
   logic       agreeRel;     // agreement channel A high: released
   logic       ackKey;       // acknowledge key pressed
   logic [3:0] pairFault;    // per pair discrepancy
   logic       agreePressed;
   logic       anyFault;

   two_channel_decoder #(.ANTIVALENT(1'b0), .TOL_CYCLES(DISC_CYCLES))
   u_estop (
      .mclk      (mclk),
      .rstN      (rstN),
      .chanA     (safeIn[`SIL_IN_ESTOP_A]),
      .chanB     (safeIn[`SIL_IN_ESTOP_B]),
      .state     (estopOk),
      .pairFault (pairFault[0])
   );

   two_channel_decoder #(.ANTIVALENT(1'b0), .TOL_CYCLES(DISC_CYCLES))
   u_door (
      .mclk      (mclk),
      .rstN      (rstN),
      .chanA     (safeIn[`SIL_IN_DOOR_A]),
      .chanB     (safeIn[`SIL_IN_DOOR_B]),
      .state     (doorClosed),
      .pairFault (pairFault[1])
   );

   two_channel_decoder #(.ANTIVALENT(1'b1), .TOL_CYCLES(DISC_CYCLES))
   u_agree (
      .mclk      (mclk),
      .rstN      (rstN),
      .chanA     (safeIn[`SIL_IN_AGREE_A]),
      .chanB     (safeIn[`SIL_IN_AGREE_B]),
      .state     (agreeRel),
      .pairFault (pairFault[2])
   );

   two_channel_decoder #(.ANTIVALENT(1'b0), .TOL_CYCLES(DISC_CYCLES))
   u_ack (
      .mclk      (mclk),
      .rstN      (rstN),
      .chanA     (safeIn[`SIL_IN_ACK_A]),
      .chanB     (safeIn[`SIL_IN_ACK_B]),
      .state     (ackKey),
      .pairFault (pairFault[3])
   );

   assign agreePressed = ~agreeRel;
   assign anyFault     = |pairFault;

   // sequencing state
   safety_interlock_pkg::lock_state_t state_q, state_d;
   safety_interlock_pkg::axis_mode_t  mode;
   logic ackPrev_q, ackPrev_d;   // ack key one cycle ago
   logic stopC_q, stopC_d;       // stop type C requested
   logic stopD_q, stopD_d;       // stop type D requested
   logic fault_q, fault_d;       // sticky discrepancy fault
   logic ackEdge;                // fresh ack key press
   logic ackTaken;               // latched state acknowledged
   logic estopTrip;              // run left by emergency stop
   logic doorPrev_q, doorPrev_d; // door state one cycle ago

   assign ackEdge  = ackKey & ~ackPrev_q;
   assign ackTaken = (state_q == safety_interlock_pkg::ST_LATCHED) &
                     ackEdge & estopOk & ~anyFault;
   assign estopTrip = (state_q == safety_interlock_pkg::ST_RUN) & ~estopOk;

   // next sequencing values
   always_comb begin
      state_d    = state_q;
      stopC_d    = stopC_q;
      stopD_d    = stopD_q;
      fault_d    = fault_q | anyFault;
      ackPrev_d  = ackKey;
      doorPrev_d = doorClosed;
      unique case (state_q)
         safety_interlock_pkg::ST_LATCHED: begin
            // ack key acts only here
            if (ackTaken) begin
               state_d = safety_interlock_pkg::ST_RUN;
               stopC_d = 1'b0;
               stopD_d = 1'b0;
               fault_d = 1'b0;
            end
         end
         safety_interlock_pkg::ST_RUN: begin
            if (anyFault) begin
               state_d = safety_interlock_pkg::ST_LATCHED;
            end else if (!estopOk) begin
               // stop type chosen from door at the trip
               state_d = safety_interlock_pkg::ST_LATCHED;
               stopC_d = ~doorClosed;
               stopD_d = doorClosed;
            end
         end
         default: begin
            // illegal code falls back to the safe latched state
            state_d = safety_interlock_pkg::ST_LATCHED;
         end
      endcase
   end

   // sequencing registers, reset into latched state
   always_ff @(posedge mclk or negedge rstN) begin
      if (!rstN) begin
         state_q    <= safety_interlock_pkg::ST_LATCHED;
         ackPrev_q  <= 1'b0;
         stopC_q    <= 1'b0;
         stopD_q    <= 1'b0;
         fault_q    <= 1'b0;
         doorPrev_q <= 1'b0;
      end else begin
         state_q    <= state_d;
         ackPrev_q  <= ackPrev_d;
         stopC_q    <= stopC_d;
         stopD_q    <= stopD_d;
         fault_q    <= fault_d;
         doorPrev_q <= doorPrev_d;
      end
   end

   // application cases: requested outputs and axis mode
   logic reqV1, reqV2, reqV3, reqSupply;
   logic running;

   assign running = (state_q == safety_interlock_pkg::ST_RUN) & estopOk &
                    ~anyFault;

   always_comb begin
      reqV1     = 1'b0;
      reqV2     = 1'b0;
      reqV3     = 1'b0;
      reqSupply = 1'b0;
      mode      = safety_interlock_pkg::safe_operating_stop;
      if (running) begin
         if (doorClosed) begin
            mode      = safety_interlock_pkg::safe_speed_level_three;
            reqV1     = 1'b1;
            reqV2     = 1'b1;
            reqV3     = 1'b1;
            reqSupply = 1'b1;
         end else if (agreePressed) begin
            mode  = safety_interlock_pkg::safe_speed_level_one;
            reqV1 = 1'b1;
            reqV3 = 1'b1;
         end else begin
            mode = safety_interlock_pkg::safe_operating_stop;
         end
      end
   end

   // registered axis selection
   safety_interlock_pkg::axis_mode_t mode_q;

   always_ff @(posedge mclk or negedge rstN) begin
      if (!rstN) begin
         mode_q <= safety_interlock_pkg::safe_operating_stop;
      end else begin
         mode_q <= mode;
      end
   end

   assign axisMode  = mode_q;
   assign stopTypeC = stopC_q;
   assign stopTypeD = stopD_q;

   // software registers
   logic [3:0] ctrl_q, ctrl_d;       // per channel shutdown
   logic [3:0] stdOut_q, stdOut_d;   // standard output requests
   logic [3:0] irqStat_q, irqStat_d; // sticky events
   logic [3:0] irqMask_q, irqMask_d; // event enables
   logic [31:0] prdata_q, prdata_d;
   logic       wrEn;
   logic       mapped;
   logic [3:0] events;
   logic [31:0] statusWord;

   // output channels, each with its own shutdown
   logic v1Out, v2Out, v3Out, supplyOut;

   output_channel_gate u_valve1 (
      .mclk     (mclk),
      .rstN     (rstN),
      .request  (reqV1),
      .shutdown (ctrl_q[`SIL_SD_VALVE1]),
      .forceOff (fault_q),
      .chanOut  (v1Out)
   );

   output_channel_gate u_valve2 (
      .mclk     (mclk),
      .rstN     (rstN),
      .request  (reqV2),
      .shutdown (ctrl_q[`SIL_SD_VALVE2]),
      .forceOff (fault_q),
      .chanOut  (v2Out)
   );

   output_channel_gate u_valve3 (
      .mclk     (mclk),
      .rstN     (rstN),
      .request  (reqV3),
      .shutdown (ctrl_q[`SIL_SD_VALVE3]),
      .forceOff (fault_q),
      .chanOut  (v3Out)
   );

   output_channel_gate u_supply (
      .mclk     (mclk),
      .rstN     (rstN),
      .request  (reqSupply),
      .shutdown (ctrl_q[`SIL_SD_SUPPLY]),
      .forceOff (fault_q),
      .chanOut  (supplyOut)
   );

   // channel placement, unused channels held low
   always_comb begin
      safeOut                   = 4'h0;
      powerOut                  = 3'h0;
      safeOut[`SIL_OUT_VALVE1]  = v1Out;
      safeOut[`SIL_OUT_VALVE2]  = v2Out;
      powerOut[`SIL_PWR_VALVE3] = v3Out;
      powerOut[`SIL_PWR_SUPPLY] = supplyOut;
   end

   // standard outputs only live while the supply is switched in
   logic [3:0] stdDrive_q;

   always_ff @(posedge mclk or negedge rstN) begin
      if (!rstN) begin
         stdDrive_q <= 4'h0;
      end else begin
         stdDrive_q <= stdOut_q & {4{supplyOut}};
      end
   end

   assign standardOut = stdDrive_q;

   // events for the interrupt status
   always_comb begin
      events               = 4'h0;
      events[`SIL_EV_ESTOP] = estopTrip;
      events[`SIL_EV_ACK]   = ackTaken;
      events[`SIL_EV_DISC]  = anyFault & ~fault_q;
      events[`SIL_EV_DOOR]  = doorPrev_q & ~doorClosed;
   end

   // status word
   always_comb begin
      statusWord = 32'h0000_0000;
      statusWord[`SIL_ST_ESTOP_OK]    = estopOk;
      statusWord[`SIL_ST_DOOR_CLOSED] = doorClosed;
      statusWord[`SIL_ST_AGREE]       = agreePressed;
      statusWord[`SIL_ST_ACK_KEY]     = ackKey;
      statusWord[`SIL_ST_LATCHED]     =
         (state_q == safety_interlock_pkg::ST_LATCHED);
      statusWord[`SIL_ST_FAULT]       = fault_q;
      statusWord[`SIL_ST_AXIS_HI:`SIL_ST_AXIS_LO] = mode_q;
      statusWord[`SIL_ST_STOP_C]      = stopC_q;
      statusWord[`SIL_ST_STOP_D]      = stopD_q;
      statusWord[`SIL_ST_PAIR_HI:`SIL_ST_PAIR_LO] = pairFault;
   end

   // apb decode, zero wait states
   assign wrEn   = psel & penable & pwrite;
   assign mapped = (paddr == `SIL_OFS_CTRL)     |
                   (paddr == `SIL_OFS_STDOUT)   |
                   (paddr == `SIL_OFS_STATUS)   |
                   (paddr == `SIL_OFS_IRQ_STAT) |
                   (paddr == `SIL_OFS_IRQ_MASK);
   assign pready  = 1'b1;
   assign pslverr = psel & penable & ~mapped;

   // next register values
   always_comb begin
      ctrl_d    = ctrl_q;
      stdOut_d  = stdOut_q;
      irqMask_d = irqMask_q;
      irqStat_d = irqStat_q;
      prdata_d  = prdata_q;
      if (wrEn) begin
         unique case (paddr)
            `SIL_OFS_CTRL:     ctrl_d    = pwdata[3:0];
            `SIL_OFS_STDOUT:   stdOut_d  = pwdata[3:0];
            `SIL_OFS_IRQ_STAT: irqStat_d = irqStat_q & ~pwdata[3:0];
            `SIL_OFS_IRQ_MASK: irqMask_d = pwdata[3:0];
            default: begin
               // read only or unmapped: nothing stored
            end
         endcase
      end
      // set wins over a clear in the same cycle
      irqStat_d = irqStat_d | events;
      // read data captured in the setup cycle
      if (psel & ~penable) begin
         unique case (paddr)
            `SIL_OFS_CTRL:     prdata_d = {28'h0, ctrl_q};
            `SIL_OFS_STDOUT:   prdata_d = {28'h0, stdOut_q};
            `SIL_OFS_STATUS:   prdata_d = statusWord;
            `SIL_OFS_IRQ_STAT: prdata_d = {28'h0, irqStat_q};
            `SIL_OFS_IRQ_MASK: prdata_d = {28'h0, irqMask_q};
            default:           prdata_d = 32'h0000_0000;
         endcase
      end
   end

   // register file
   always_ff @(posedge mclk or negedge rstN) begin
      if (!rstN) begin
         ctrl_q    <= `SIL_CTRL_RST;
         stdOut_q  <= `SIL_STDOUT_RST;
         irqStat_q <= `SIL_IRQ_RST;
         irqMask_q <= `SIL_IRQ_RST;
         prdata_q  <= 32'h0000_0000;
      end else begin
         ctrl_q    <= ctrl_d;
         stdOut_q  <= stdOut_d;
         irqStat_q <= irqStat_d;
         irqMask_q <= irqMask_d;
         prdata_q  <= prdata_d;
      end
   end

   assign prdata = prdata_q;
   assign irq    = |(irqStat_q & irqMask_q);

endmodule : safety_interlock_logic

// File: include/safety_interlock_defs.svh
// offsets, bit positions, reset values and channel indices of the interlock
`ifndef SAFETY_INTERLOCK_DEFS_SVH
`define SAFETY_INTERLOCK_DEFS_SVH

// register byte offsets
`define SIL_OFS_CTRL       8'h00
`define SIL_OFS_STDOUT     8'h04
`define SIL_OFS_STATUS     8'h08
`define SIL_OFS_IRQ_STAT   8'h0C
`define SIL_OFS_IRQ_MASK   8'h10

// reset values
`define SIL_CTRL_RST       4'h0
`define SIL_STDOUT_RST     4'h0
`define SIL_IRQ_RST        4'h0
`define SIL_PAIR_STATE_RST 1'b0

// shutdown control bits in the control register
`define SIL_SD_VALVE1      0
`define SIL_SD_VALVE2      1
`define SIL_SD_VALVE3      2
`define SIL_SD_SUPPLY      3

// interrupt event bits
`define SIL_EV_ESTOP       0
`define SIL_EV_ACK         1
`define SIL_EV_DISC        2
`define SIL_EV_DOOR        3

// status register fields
`define SIL_ST_ESTOP_OK    0
`define SIL_ST_DOOR_CLOSED 1
`define SIL_ST_AGREE       2
`define SIL_ST_ACK_KEY     3
`define SIL_ST_LATCHED     4
`define SIL_ST_FAULT       5
`define SIL_ST_AXIS_LO     6
`define SIL_ST_AXIS_HI     7
`define SIL_ST_STOP_C      8
`define SIL_ST_STOP_D      9
`define SIL_ST_PAIR_LO     10
`define SIL_ST_PAIR_HI     13

// safe input unit channel numbers
`define SIL_IN_ESTOP_A     0
`define SIL_IN_ESTOP_B     4
`define SIL_IN_DOOR_A      1
`define SIL_IN_DOOR_B      5
`define SIL_IN_AGREE_A     2
`define SIL_IN_AGREE_B     6
`define SIL_IN_ACK_A       3
`define SIL_IN_ACK_B       7

// output channel numbers
`define SIL_OUT_VALVE1     0
`define SIL_OUT_VALVE2     2
`define SIL_PWR_VALVE3     0
`define SIL_PWR_SUPPLY     2

`endif

// File: include/safety_interlock_pkg.sv
// types shared by the interlock design
package safety_interlock_pkg;

   // axis monitoring selection
   typedef enum logic [1:0] {
      safe_operating_stop    = 2'b00,
      safe_speed_level_one   = 2'b01,
      safe_speed_level_three = 2'b10
   } axis_mode_t;

   // interlock sequencing states
   typedef enum logic [1:0] {
      ST_LATCHED = 2'b00,
      ST_RUN     = 2'b01
   } lock_state_t;

endpackage : safety_interlock_pkg

// File: design/two_channel_decoder.sv
// decoder for one two-channel sensor pair with discrepancy timeout
`timescale 1ns/100ps
`include "safety_interlock_defs.svh"

module two_channel_decoder #(
   parameter bit ANTIVALENT = 1'b0, // channels must differ when set
   parameter int TOL_CYCLES = 16    // cycles an invalid pair is tolerated
) (
   // clock and reset
   input  wire logic mclk,
   input  wire logic rstN,
   // sensor channels
   input  wire logic chanA,
   input  wire logic chanB,
   // decoded result
   output logic      state,
   output logic      pairFault
);

   localparam int CW = $clog2(TOL_CYCLES + 1);
   localparam logic [CW-1:0] TOL = CW'(TOL_CYCLES);

   logic          pairValid;      // channels show a legal combination
   logic [CW-1:0] cnt_q, cnt_d;   // cycles spent invalid
   logic          state_q, state_d;
   logic          fault_q, fault_d;

   assign pairValid = ANTIVALENT ? (chanA != chanB) : (chanA == chanB);

   // next values: hold last good state, count invalid time
   always_comb begin
      cnt_d   = cnt_q;
      state_d = state_q;
      fault_d = fault_q;
      if (pairValid) begin
         cnt_d   = '0;
         state_d = chanA;
         fault_d = 1'b0;
      end else if (cnt_q != TOL) begin
         cnt_d = cnt_q + CW'(1);
      end else begin
         fault_d = 1'b1;
      end
   end

   // registers
   always_ff @(posedge mclk or negedge rstN) begin
      if (!rstN) begin
         cnt_q   <= '0;
         state_q <= `SIL_PAIR_STATE_RST;
         fault_q <= 1'b0;
      end else begin
         cnt_q   <= cnt_d;
         state_q <= state_d;
         fault_q <= fault_d;
      end
   end

   assign state     = state_q;
   assign pairFault = fault_q;

endmodule : two_channel_decoder

// File: design/output_channel_gate.sv
// one safe output channel with its own shutdown control
`timescale 1ns/100ps

module output_channel_gate (
   // clock and reset
   input  wire logic mclk,
   input  wire logic rstN,
   // control
   input  wire logic request,
   input  wire logic shutdown,
   input  wire logic forceOff,
   // channel drive
   output logic      chanOut
);

   logic out_q, out_d; // registered drive, low is safe

   // next value: any off term wins
   always_comb begin
      out_d = request & ~shutdown & ~forceOff;
   end

   // register
   always_ff @(posedge mclk or negedge rstN) begin
      if (!rstN) begin
         out_q <= 1'b0;
      end else begin
         out_q <= out_d;
      end
   end

   assign chanOut = out_q;

endmodule : output_channel_gate

// File: dv/interlock_field_model.sv
// sensor contacts and downstream standard module around the interlock
`timescale 1ns/100ps

module interlock_field_model (
   // commanded sensor states
   input  wire logic       estopPressed,
   input  wire logic       doorClosed,
   input  wire logic       agreePressed,
   input  wire logic       ackPressed,
   input  wire logic       estopSkew,   // breaks the estop pair
   // interlock outputs
   input  wire logic [3:0] standardOut,
   input  wire logic [2:0] powerOut,
   // contact levels and live standard outputs
   output logic      [7:0] safeIn,
   output logic      [3:0] stdLive
);
   // two contacts per sensor on channel n and n+4
   always_comb begin
      safeIn[0] = !estopPressed;
      safeIn[4] = !estopPressed ^ estopSkew;
      safeIn[1] = doorClosed;
      safeIn[5] = doorClosed;
      safeIn[2] = !agreePressed;
      safeIn[6] = agreePressed;
      safeIn[3] = ackPressed;
      safeIn[7] = ackPressed;
   end
   // standard module loses both rails with the cutoff
   assign stdLive = standardOut & {4{powerOut[2]}};
endmodule : interlock_field_model

// File: dv/safety_interlock_asserts.sv
// port assertions for the interlock
`timescale 1ns/100ps
`include "safety_interlock_defs.svh"

module safety_interlock_asserts #(
   parameter int DISC_CYCLES = 16  // discrepancy tolerance
) (
   // clock and reset
   input  wire logic       mclk,
   input  wire logic       reset_n,
   // sensors and outputs
   input  wire logic [7:0] safeIn,
   input  wire logic [3:0] safeOut,
   input  wire logic [2:0] powerOut,
   input  wire logic [1:0] axisMode,
   input  wire logic       stopTypeC,
   input  wire logic       stopTypeD,
   // apb
   input  wire logic       psel,
   input  wire logic       penable,
   input  wire logic [7:0] paddr,
   input  wire logic       pslverr
);
   default clocking @(posedge mclk); endclocking
   default disable iff (!reset_n);
   logic [7:0] skewCnt_q;  // cycles the estop pair disagrees
   logic [7:0] skewCnt_d;  // next count
   // saturating count of disagreeing cycles
   always_comb begin
      skewCnt_d = skewCnt_q;
      if (safeIn[0] == safeIn[4]) begin
         skewCnt_d = 8'h00;
      end else if (skewCnt_q != 8'hFF) begin
         skewCnt_d = skewCnt_q + 8'h01;
      end
   end
   // count register
   always_ff @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
         skewCnt_q <= 8'h00;
      end else begin
         skewCnt_q <= skewCnt_d;
      end
   end
   a_unused_chan_low: assert property (
      !safeOut[1] && !safeOut[3] && !powerOut[1])
      else $error("unused channel driven");
   a_supply_speed_three: assert property (
      powerOut[2] |-> axisMode == safety_interlock_pkg::safe_speed_level_three)
      else $error("supply on outside full speed");
   a_stop_all_off: assert property (
      axisMode == safety_interlock_pkg::safe_operating_stop
      |-> safeOut == 4'h0 && powerOut == 3'h0)
      else $error("output on during standstill");
   a_speed_one_valves: assert property (
      axisMode == safety_interlock_pkg::safe_speed_level_one
      |-> !safeOut[2] && !powerOut[2])
      else $error("valve two or supply on at speed one");
   a_stop_type_stop: assert property (
      stopTypeC || stopTypeD |=> !(stopTypeC && stopTypeD)
      && axisMode == safety_interlock_pkg::safe_operating_stop)
      else $error("stop type without standstill");
   a_estop_cuts_all: assert property (
      (!safeIn[0] && !safeIn[4]) [*4] |=> safeOut == 4'h0 && powerOut == 3'h0)
      else $error("outputs on with estop pressed");
   a_door_cuts_supply: assert property (
      (!safeIn[1] && !safeIn[5]) [*4] |=> !powerOut[2])
      else $error("supply on with door open");
   a_skew_forces_off: assert property (
      skewCnt_q > DISC_CYCLES + 6 |-> safeOut == 4'h0 && powerOut == 3'h0)
      else $error("outputs on during pair discrepancy");
   a_error_in_access: assert property (
      pslverr == (psel && penable && (paddr[1:0] != 2'h0 ||
      paddr > `SIL_OFS_IRQ_MASK)))
      else $error("bus error flag wrong for address");
   c_run_entered: cover property ($rose(powerOut[2]));
   c_stop_c: cover property ($rose(stopTypeC));
   c_stop_d: cover property ($rose(stopTypeD));
   c_bus_error: cover property (pslverr);
endmodule : safety_interlock_asserts

bind safety_interlock_logic safety_interlock_asserts #(
   .DISC_CYCLES(DISC_CYCLES)
) chk (.mclk(mclk), .reset_n(reset_n), .safeIn(safeIn), .safeOut(safeOut),
   .powerOut(powerOut), .axisMode(axisMode), .stopTypeC(stopTypeC),
   .stopTypeD(stopTypeD), .psel(psel), .penable(penable), .paddr(paddr),
   .pslverr(pslverr));

// File: dv/safety_interlock_logic_test.sv
// self-checking bench for the interlock with its field model
`timescale 1ns/100ps
`include "safety_interlock_defs.svh"

module safety_interlock_logic_test;
   localparam int DISC = 2;           // short discrepancy tolerance
   logic        mclk = 1'b0;          // system clock
   logic        reset_n = 1'b0;       // async reset
   logic        estopPressed = 1'b0;  // commanded sensor states
   logic        doorClosed = 1'b1;
   logic        agreePressed = 1'b0;
   logic        ackPressed = 1'b0;
   logic        estopSkew = 1'b0;
   logic        psel = 1'b0;          // apb request
   logic        penable = 1'b0;
   logic        pwrite = 1'b0;
   logic [7:0]  paddr = 8'h00;
   logic [31:0] pwdata = 32'h0;
   logic [31:0] prdata;
   logic        pready;
   logic        pslverr;
   logic [7:0]  safeIn;
   logic [3:0]  safeOut;
   logic [2:0]  powerOut;
   logic [3:0]  standardOut;
   logic [3:0]  stdLive;
   logic [1:0]  axisMode;
   logic        stopTypeC;
   logic        stopTypeD;
   logic        irq;
   logic [31:0] q;                    // last read word
   logic        e;                    // last error flag
   int          bad_count = 0;
   int          n_tests = 0;
   // output bit dropped by each shutdown control
   logic [8:0]  sdBit [4] = '{9'h020, 9'h080, 9'h004, 9'h010};

   safety_interlock_logic #(.DISC_CYCLES(DISC)) dut (.mclk(mclk),
      .reset_n(reset_n), .safeIn(safeIn), .safeOut(safeOut),
      .powerOut(powerOut), .standardOut(standardOut), .axisMode(axisMode),
      .stopTypeC(stopTypeC), .stopTypeD(stopTypeD), .irq(irq), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .prdata(prdata), .pready(pready), .pslverr(pslverr));
   interlock_field_model model (.estopPressed(estopPressed),
      .doorClosed(doorClosed), .agreePressed(agreePressed),
      .ackPressed(ackPressed), .estopSkew(estopSkew),
      .standardOut(standardOut), .powerOut(powerOut), .safeIn(safeIn),
      .stdLive(stdLive));

   // clock generator
   initial begin
      forever #25 mclk = ~mclk;
   end

   // compare and count
   task automatic check(input string w, input logic [31:0] seen, exp);
      n_tests++;
      if (seen !== exp) begin
         bad_count++;
         $display("CHECK FAILED %s expected %h seen %h", w, exp, seen);
      end
   endtask : check

   // one apb transfer, returns at the edge after the answer
   task automatic xfer(input logic wr, input logic [7:0] a,
                       input logic [31:0] d);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge mclk);
      penable <= 1'b1;
      // this wait ends at the first edge that sees pready high
      do begin
         @(posedge mclk);
      end while (pready !== 1'b1);
      q = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge mclk);
   endtask : xfer

   // read and compare masked bits
   task automatic rdChk(input string w, input logic [7:0] a,
                        input logic [31:0] m, x);
      xfer(1'b0, a, 32'h0);
      check(w, q & m, x);
   endtask : rdChk

   // {safeOut, powerOut, axisMode} for a state and sensor set
   function automatic logic [8:0] expOut(input logic run, dc, ag);
      if (!run) return {7'h00, safety_interlock_pkg::safe_operating_stop};
      if (dc) return {7'h2D, safety_interlock_pkg::safe_speed_level_three};
      if (ag) return {7'h09, safety_interlock_pkg::safe_speed_level_one};
      return {7'h00, safety_interlock_pkg::safe_operating_stop};
   endfunction : expOut

   // compare outputs against the current sensor commands
   task automatic chkOut(input logic run);
      check("outputs", {safeOut, powerOut, axisMode},
            expOut(run, doorClosed, agreePressed));
   endtask : chkOut

   // let sensor changes reach the outputs
   task automatic settle();
      repeat (4) @(posedge mclk);
   endtask : settle

   // counts and verdict
   task automatic print_verdict();
      $display("comparisons %0d mismatches %0d", n_tests, bad_count);
      if (bad_count == 0 && n_tests > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
   endtask : print_verdict

   // hang guard
   initial begin
      repeat (5000) @(posedge mclk);
      bad_count++;
      print_verdict();
   end

   // main sequence
   initial begin
      void'($urandom(32'hCF23));
      repeat (2) @(posedge mclk);
      reset_n <= 1'b1;
      settle();
      chkOut(1'b0);
      rdChk("latched", `SIL_OFS_STATUS, 32'h10, 32'h10);
      ackPressed <= 1'b1;
      settle();
      chkOut(1'b1);
      check("irq masked", irq, 32'h0);
      xfer(1'b1, `SIL_OFS_IRQ_MASK, 32'h2);
      check("irq raised", irq, 32'h1);
      xfer(1'b1, `SIL_OFS_IRQ_STAT, 32'h2);
      check("irq cleared", irq, 32'h0);
      xfer(1'b1, `SIL_OFS_STDOUT, 32'hA);
      settle();
      check("std live", stdLive, 32'hA);
      for (int i = 0; i < 4; i++) begin
         xfer(1'b1, `SIL_OFS_CTRL, 32'h1 << i);
         settle();
         check("shutdown", {safeOut, powerOut, axisMode},
               expOut(1'b1, 1'b1, agreePressed) & ~sdBit[i]);
      end
      xfer(1'b1, `SIL_OFS_CTRL, 32'h0);
      repeat (20) begin
         doorClosed <= 1'($urandom);
         agreePressed <= 1'($urandom);
         ackPressed <= 1'($urandom);
         settle();
         chkOut(1'b1);
      end
      for (int d = 0; d < 2; d++) begin
         ackPressed <= 1'b0;
         doorClosed <= d[0];
         agreePressed <= 1'b1;
         settle();
         estopPressed <= 1'b1;
         settle();
         chkOut(1'b0);
         check("stop type", {stopTypeC, stopTypeD}, d ? 1 : 2);
         check("std cut", stdLive, 32'h0);
         ackPressed <= 1'b1;
         settle();
         chkOut(1'b0);
         ackPressed <= 1'b0;
         estopPressed <= 1'b0;
         settle();
         ackPressed <= 1'b1;
         settle();
         chkOut(1'b1);
         check("stop gone", {stopTypeC, stopTypeD}, 32'h0);
      end
      ackPressed <= 1'b0;
      estopSkew <= 1'b1;
      repeat (DISC + 6) @(posedge mclk);
      chkOut(1'b0);
      rdChk("fault", `SIL_OFS_STATUS, 32'h20, 32'h20);
      estopSkew <= 1'b0;
      settle();
      ackPressed <= 1'b1;
      settle();
      chkOut(1'b1);
      xfer(1'b0, 8'h14, 32'h0);
      check("unmapped error", e, 32'h1);
      check("unmapped data", q, 32'h0);
      print_verdict();
   end
endmodule : safety_interlock_logic_test
